// ==== cps_defines.vh ====
// Constants for the current and power scaling engine
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH
// Wishbone word offsets (byte addresses)
`define CPS_OFF_CONFIG 8'h00
`define CPS_OFF_SHUNT 8'h04
`define CPS_OFF_BUS 8'h08
`define CPS_OFF_POWER 8'h0C
`define CPS_OFF_CURRENT 8'h10
`define CPS_OFF_CALIB 8'h14
`define CPS_OFF_STATUS 8'h18
// Reset values
`define CPS_CONFIG_RST 16'h399F
`define CPS_CALIB_RST 16'h0000
// Configuration field positions
`define CPS_CFG_RST_BIT 15
`define CPS_CFG_BRNG_BIT 13
`define CPS_CFG_PGA_HI 12
`define CPS_CFG_PGA_LO 11
`define CPS_CFG_MODE_HI 2
`define CPS_CFG_MODE_LO 0
// Scaling constants
`define CPS_CUR_DIV_SHIFT 12
`define CPS_PWR_DIV 32'd5000
`define CPS_BUS_SHIFT 3
`endif

// ==== cps_divider.v ====
// Restoring unsigned divider used for the power result
`timescale 1ns/1ps
`default_nettype none
module cps_divider #(
  parameter W = 32
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Request
  input wire start,
  input wire [W-1:0] dividend,
  input wire [W-1:0] divisor,
  // Result
  output reg busy,
  output reg done,
  output reg [W-1:0] quotient
);
  reg [W-1:0] rem_q;
  reg [W-1:0] num_q;
  reg [5:0] cnt_q;
  wire [W:0] trial;
  assign trial = {rem_q, num_q[W-1]} - {1'b0, divisor};
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= {W{1'b0}};
      rem_q <= {W{1'b0}};
      num_q <= {W{1'b0}};
      cnt_q <= 6'h00;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        rem_q <= {W{1'b0}};
        num_q <= dividend;
        cnt_q <= W[5:0];
      end
      else if (busy)
      begin
        // Quotient bits shift into num_q as the dividend shifts out
        if (!trial[W])
        begin
          rem_q <= trial[W-1:0];
          num_q <= {num_q[W-2:0], 1'b1};
        end
        else
        begin
          rem_q <= {rem_q[W-2:0], num_q[W-1]};
          num_q <= {num_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          quotient <= trial[W] ? {num_q[W-2:0], 1'b0}
                               : {num_q[W-2:0], 1'b1};
        end
      end
    end
  end
endmodule // cps_divider
`default_nettype wire

// ==== cps_scaling.v ====
// Current and power scaling engine with Wishbone register access
// What this block does
// RQ1: Defaults give 12-bit, 320mV, 32V, continuous.
// RQ2: Current and power valid only after calibration.
// RQ3: Registers volatile, defaults restored at reset.
// RQ4: Bus LSB 4mV, power LSB twenty current LSBs.
// RQ5: Host sets cal to 0.04096 over LSB*R.
// RQ6: Host may trim cal by measured current.
// RQ7: Current equals shunt times cal over 4096.
// RQ8: Power equals current times bus over 5000.
// RQ9: Calibration resets zero, results read zero.
// RQ10: Bus register read needs right shift by three.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.vh"
module cps_scaling (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Converter results
  input wire conv_valid,
  input wire [15:0] shunt_raw,
  input wire [12:0] bus_raw,
  // Converter settings
  output wire [1:0] pga_sel,
  output wire bus_range_32v,
  output wire [2:0] conv_mode
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 2'b00;
  localparam ST_MULT = 2'b01;
  localparam ST_DIV = 2'b10;

  reg [15:0] config_q;
  reg [15:0] calib_q;
  reg [15:0] shunt_q;
  reg [15:0] bus_q;
  reg [15:0] current_q;
  reg [15:0] power_q;
  reg ready_q;
  reg ovf_q;
  reg ack_q;
  reg [1:0] state_q;
  reg [12:0] bus_pend_q;
  reg div_start_q;
  wire div_busy;
  wire div_done;
  wire [31:0] div_quot;
  wire div_rst_n;
  wire [31:0] prod;
  wire [15:0] cur_scaled;
  wire cur_ovf;
  wire [31:0] cur_abs;
  wire [31:0] pwr_prod;
  wire bus_req;
  wire wr_req;
  wire rd_req;
  wire wr_config;
  wire wr_calib;
  wire rd_status;
  wire soft_rst;
  reg [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; a request is taken only while ack is low
  assign wb_ack_o = ack_q;
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_req = bus_req && wb_we_i;
  assign rd_req = bus_req && !wb_we_i;
  assign wr_config = wr_req && wb_adr_i == `CPS_OFF_CONFIG;
  assign wr_calib = wr_req && wb_adr_i == `CPS_OFF_CALIB;
  assign rd_status = rd_req && wb_adr_i == `CPS_OFF_STATUS;
  // Software reset takes the power-up path, except for ack_q and wb_dat_o [RQ3]
  assign soft_rst = wr_config && wb_sel_i[1]
                    && wb_dat_i[`CPS_CFG_RST_BIT];
  // Divider restarts too, so no stale quotient survives
  assign div_rst_n = reset_n && !soft_rst;
  // Defaults drive the converter with no programming [RQ1]
  assign pga_sel = config_q[`CPS_CFG_PGA_HI:`CPS_CFG_PGA_LO];
  assign bus_range_32v = config_q[`CPS_CFG_BRNG_BIT];
  assign conv_mode = config_q[`CPS_CFG_MODE_HI:`CPS_CFG_MODE_LO];

  ////////////////////////////////////////////////////////////////////////
  // Signed shunt times unsigned calibration, then divide by 4096
  assign prod = $signed(shunt_q) * $signed({1'b0, calib_q}); // [RQ7]
  assign cur_scaled = prod[`CPS_CUR_DIV_SHIFT+15:`CPS_CUR_DIV_SHIFT]; // [RQ7]
  // Bits above the sign of the result must all agree
  assign cur_ovf = (prod[31:27] != 5'h00) && (prod[31:27] != 5'h1F);
  assign cur_abs = current_q[15] ? {16'h0000, -current_q}
                                 : {16'h0000, current_q};
  assign pwr_prod = cur_abs * {19'h00000, bus_pend_q}; // [RQ8]

  ////////////////////////////////////////////////////////////////////////
  // One-cycle ack per request, software reset included
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, each byte lane under its own select
  always @(posedge clk)
  begin
    if (!reset_n || soft_rst)
    begin
      // Everything back to defaults, software reset included [RQ3]
      config_q <= `CPS_CONFIG_RST; // [RQ1]
      calib_q <= `CPS_CALIB_RST; // [RQ9]
    end
    else
    begin
      if (wr_config)
      begin
        if (wb_sel_i[0])
        begin
          config_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          config_q[15:8] <= wb_dat_i[15:8];
        end
      end
      else if (wr_calib)
      begin
        // Bit 0 is not used by the engine and reads zero
        if (wb_sel_i[0])
        begin
          calib_q[7:0] <= {wb_dat_i[7:1], 1'b0};
        end
        if (wb_sel_i[1])
        begin
          calib_q[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: capture, multiply, divide
  always @(posedge clk)
  begin
    if (!reset_n || soft_rst)
    begin
      state_q <= ST_IDLE;
      div_start_q <= 1'b0;
    end
    else
    begin
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // New pairs are ignored until the last result is out
          if (conv_valid)
          begin
            state_q <= ST_MULT;
          end
        end
        ST_MULT:
        begin
          state_q <= ST_DIV;
          div_start_q <= 1'b1;
        end
        ST_DIV:
        begin
          if (div_done)
          begin
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Converter results, captured only while idle
  always @(posedge clk)
  begin
    if (!reset_n || soft_rst)
    begin
      shunt_q <= 16'h0000;
      bus_q <= 16'h0000;
      bus_pend_q <= 13'h0000;
    end
    else if (state_q == ST_IDLE && conv_valid)
    begin
      // Shunt readable regardless of calibration [RQ2]
      shunt_q <= shunt_raw;
      // Bus held left-aligned, reader shifts by three [RQ10]
      bus_q <= {bus_raw, 3'b000};
      bus_pend_q <= bus_raw;
    end
  end

  // Current and power results
  always @(posedge clk)
  begin
    if (!reset_n || soft_rst)
    begin
      current_q <= 16'h0000;
      ovf_q <= 1'b0;
      power_q <= 16'h0000;
    end
    else
    begin
      if (state_q == ST_MULT)
      begin
        // Zero calibration gives zero current and power [RQ9] [RQ2]
        current_q <= cur_scaled; // [RQ7]
        ovf_q <= cur_ovf;
      end
      if (state_q == ST_DIV && div_done)
      begin
        // Power LSB is twenty current LSBs via 4mV bus [RQ4]
        power_q <= div_quot[15:0]; // [RQ8]
      end
    end
  end

  // Ready: a status read clears it, a new result wins
  always @(posedge clk)
  begin
    if (!reset_n || soft_rst)
    begin
      ready_q <= 1'b0;
    end
    else if (state_q == ST_DIV && div_done)
    begin
      ready_q <= 1'b1;
    end
    else if (rd_status)
    begin
      ready_q <= 1'b0;
    end
  end

  cps_divider #(
    .W(32)
  ) u_div (
    .clk(clk),
    .reset_n(div_rst_n),
    .start(div_start_q),
    .dividend(pwr_prod),
    .divisor(`CPS_PWR_DIV), // [RQ8]
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quot)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data selection; unmapped addresses read zero
  always @*
  begin
    rd_mux = 32'h00000000;
    if (wb_adr_i == `CPS_OFF_CONFIG)
    begin
      rd_mux = {16'h0000, config_q};
    end
    else if (wb_adr_i == `CPS_OFF_SHUNT)
    begin
      rd_mux = {16'h0000, shunt_q};
    end
    else if (wb_adr_i == `CPS_OFF_BUS)
    begin
      rd_mux = {16'h0000, bus_q};
    end
    else if (wb_adr_i == `CPS_OFF_POWER)
    begin
      rd_mux = {16'h0000, power_q};
    end
    else if (wb_adr_i == `CPS_OFF_CURRENT)
    begin
      rd_mux = {16'h0000, current_q};
    end
    else if (wb_adr_i == `CPS_OFF_CALIB)
    begin
      rd_mux = {16'h0000, calib_q};
    end
    else if (wb_adr_i == `CPS_OFF_STATUS)
    begin
      rd_mux = {29'h00000000, div_busy, ovf_q, ready_q};
    end
  end

  // Read data registered with the ack
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else if (rd_req)
    begin
      wb_dat_o <= rd_mux;
    end
  end

  // Fraction bits, upper quotient and upper lanes carry nothing here
  wire unused_ok = &{1'b0, prod[11:0], div_quot[31:16], wb_dat_i[31:16],
                     wb_sel_i[3:2]};
endmodule // cps_scaling
`default_nettype wire

// ==== cps_chk_assertions.sv ====
// Port checker for the scaling engine
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.vh"
module cps_chk (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Settings
  input wire [1:0] pga_sel,
  input wire bus_range_32v,
  input wire [2:0] conv_mode
);
  wire [5:0] cfg = {pga_sel, bus_range_32v, conv_mode};
  wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  wire rd = wb_ack_o && !wb_we_i;
  wire wcfg = wr && wb_adr_i == `CPS_OFF_CONFIG;
  wire srst = wcfg && wb_sel_i[1] && wb_dat_i[15];
  wire [5:0] wcfg_val = {wb_dat_i[12:11], wb_dat_i[13], wb_dat_i[2:0]};
  // Sticky once calibrated, so the zero checks never misfire
  reg cal_q;
  always @(posedge clk)
    if (!reset_n || srst)
      cal_q <= 1'b0;
    else if (wr && wb_adr_i == `CPS_OFF_CALIB && |wb_dat_i[15:1])
      cal_q <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reset_dflt: assert property (disable iff (1'b0) !reset_n |=>
    cfg == 6'h3F) else $error("settings not default after reset");
  a_sw_reset: assert property (srst |-> ##2 cfg == 6'h3F)
    else $error("software reset lost defaults");
  a_cfg_write: assert property (wcfg && wb_sel_i == 4'h3 &&
    !wb_dat_i[15] |-> ##2 cfg == $past(wcfg_val, 2))
    else $error("settings not written");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_cur_zero: assert property (rd && !cal_q &&
    wb_adr_i == `CPS_OFF_CURRENT |-> wb_dat_o == 32'h0)
    else $error("current nonzero uncalibrated");
  a_pwr_zero: assert property (rd && !cal_q &&
    wb_adr_i == `CPS_OFF_POWER |-> wb_dat_o == 32'h0)
    else $error("power nonzero uncalibrated");
  a_bus_align: assert property (rd && wb_adr_i == `CPS_OFF_BUS |->
    wb_dat_o[2:0] == 3'h0 && wb_dat_o[31:16] == 16'h0)
    else $error("bus value misaligned");
  cover property (srst);
  cover property (rd && cal_q && wb_adr_i == `CPS_OFF_POWER);
  cover property (wcfg && !wb_dat_i[15]);
endmodule // cps_chk
`default_nettype wire

// ==== cps_host.sv ====
// Host model: classic bus cycles and calibration arithmetic
`timescale 1ns/1ps
`default_nettype none
module cps_host (
  // Clock
  input wire clk,
  // Bus toward the engine
  output logic cyc = 1'b0,
  output logic stb = 1'b0,
  output logic we = 1'b0,
  output logic [7:0] adr = 8'h00,
  output logic [31:0] dat = 32'h0,
  input wire ack,
  input wire [31:0] rdat
);
  // Request held until ack is sampled; no latency assumed
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Current step in uA, shunt in mOhm
  function automatic logic [15:0] cal_of(input longint a, input longint r);
    return 16'(40960000 / (a * r));
  endfunction
  // Bus register is left-aligned; drop three bits for 4mV steps
  function automatic logic [12:0] bus_lsb(input logic [15:0] r);
    return r[15:3];
  endfunction
  function automatic logic [15:0] trim(input longint c, m, s);
    return 16'(c * m / s);
  endfunction
endmodule // cps_host
`default_nettype wire

// ==== testbench.sv ====
// Testbench for the scaling engine
`timescale 1ns/1ps
`default_nettype none
`include "cps_defines.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic conv_valid = 1'b0;
  logic [15:0] shunt_raw = 16'h0000;
  logic [12:0] bus_raw = 13'h0000;
  logic [15:0] q;
  int n_mismatch = 0;
  int total_checks = 0;
  wire cyc, stb, we, ack, rng;
  wire [7:0] adr;
  wire [31:0] di, dq;
  wire [1:0] pga;
  wire [2:0] mode;
  cps_host host_u (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .dat(di), .ack(ack), .rdat(dq));
  cps_scaling dut_u (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack), .conv_valid(conv_valid),
    .shunt_raw(shunt_raw), .bus_raw(bus_raw), .pga_sel(pga),
    .bus_range_32v(rng), .conv_mode(mode));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    host_u.xfer(1'b0, a, 16'h0000, q);
    `CHK("read", e, q)
  endtask
  task conv(input logic [15:0] s, input logic [12:0] b);
    conv_valid <= 1'b1;
    shunt_raw <= s;
    bus_raw <= b;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
    q = 16'h0000;
    // Poll ready; each poll also clears it for the next round
    while (q[0] !== 1'b1) host_u.xfer(1'b0, `CPS_OFF_STATUS, 16'h0, q);
  endtask
  task t_scale(input logic [15:0] s, input logic [12:0] b,
    input logic [15:0] c);
    longint i;
    longint p;
    i = (longint'($signed(s)) * longint'(c)) >>> 12;
    p = (i < 0 ? -i : i) * longint'(b) / 5000;
    host_u.xfer(1'b1, `CPS_OFF_CALIB, c, q);
    conv(s, b);
    rd(`CPS_OFF_CURRENT, i[15:0]);
    rd(`CPS_OFF_POWER, p[15:0]);
    rd(`CPS_OFF_BUS, {b, 3'h0});
    `CHK("bus4mv", b, host_u.bus_lsb(q))
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK("dflt", 6'h3F, {pga, rng, mode})
    rd(`CPS_OFF_CONFIG, 16'h399F);
    conv(16'h07D0, 13'd2995);
    rd(`CPS_OFF_SHUNT, 16'h07D0);
    rd(`CPS_OFF_CURRENT, 16'h0000);
    rd(`CPS_OFF_POWER, 16'h0000);
    t_scale(16'h07D0, 13'd2995, host_u.cal_of(1000, 2));
    t_scale(16'hF830, 13'd2995, 16'h5000);
    t_scale(16'h7FFF, 13'h1FFF, host_u.cal_of(20, 500));
    t_scale(16'h8000, 13'd100, host_u.trim(4096, 550000, 634840));
    rd(`CPS_OFF_CALIB, 16'd3548);
    host_u.xfer(1'b1, `CPS_OFF_CONFIG, 16'h019F, q);
    `CHK("cfg", 6'h07, {pga, rng, mode})
    host_u.xfer(1'b1, `CPS_OFF_CONFIG, 16'h8000, q);
    `CHK("swrst", 6'h3F, {pga, rng, mode})
    rd(`CPS_OFF_CALIB, 16'h0000);
    rd(`CPS_OFF_CURRENT, 16'h0000);
    rd(8'h1C, 16'h0000);
    final_report;
  end
  initial
  begin
    // Far beyond the few hundred cycles the sequence needs
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule // testbench
bind cps_scaling cps_chk chk_u (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pga_sel(pga_sel),
  .bus_range_32v(bus_range_32v), .conv_mode(conv_mode));
`default_nettype wire
